//--- sspf_detect.sv
`timescale 1ns/1ps
`default_nettype none

package sspf_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCL_HALF_NS = 5000;
  localparam int SCL_HALF_CYC = SCL_HALF_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 11;
  localparam logic [DIV_W-1:0] DIV_RELOAD = DIV_W'(SCL_HALF_CYC - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = 11'h000;

  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_SLAVE = 8'h08;
  localparam logic [7:0] ADDR_BUFFER = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_IDLE = 8'h18;

  localparam int ST_STOP = 4;
  localparam int ST_START = 3;
  localparam int ST_RW = 2;
  localparam int ST_UA = 1;
  localparam int ST_BF = 0;

  localparam int CTL_W = 13;
  localparam int CTL_MASTER = 0;
  localparam int CTL_TENBIT = 1;
  localparam int CTL_ENABLE = 5;
  localparam int CTL_SEN = 8;
  localparam int CTL_REPEAT_START_ENABLE = 9;
  localparam int CTL_PEN = 10;
  localparam int CTL_RECEIVE_ENABLE = 11;
  localparam int CTL_ACK_SEQUENCE_ENABLE = 12;
  localparam logic [CTL_W-1:0] CTL_RESET = 13'h0000;

  localparam int IRQ_W = 3;
  localparam int IRQ_BYTE = 0;
  localparam int IRQ_START = 1;
  localparam int IRQ_STOP = 2;

  localparam logic [4:0] TENBIT_HDR = 5'h1E;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_DONE = 4'h8;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  typedef enum logic [2:0] {
    SLV_IDLE,
    SLV_ADDR,
    SLV_RX,
    SLV_ACK,
    SLV_TX,
    SLV_TACK
  } sspf_slv_e;

  typedef enum logic [1:0] {
    MPH_DATA,
    MPH_HIGH,
    MPH_LOW
  } sspf_mph_e;
endpackage : sspf_pkg

module sspf_cond_det
  import sspf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_s,
  output logic sda_s,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_p,
  output logic stop_p
);
  logic scl_meta_reg, scl_sync_reg, scl_last_reg;
  logic sda_meta_reg, sda_sync_reg, sda_last_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_last_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_last_reg <= 1'b1;
    end else begin
      scl_meta_reg <= scl_i;
      scl_sync_reg <= scl_meta_reg;
      scl_last_reg <= scl_sync_reg;
      sda_meta_reg <= sda_i;
      sda_sync_reg <= sda_meta_reg;
      sda_last_reg <= sda_sync_reg;
    end
  end

  // A data change while the clock line stays high marks a bus condition.
  always_comb begin
    scl_s = scl_sync_reg;
    sda_s = sda_sync_reg;
    scl_rise = scl_sync_reg & ~scl_last_reg;
    scl_fall = ~scl_sync_reg & scl_last_reg;
    start_p = scl_sync_reg & scl_last_reg & sda_last_reg & ~sda_sync_reg;
    stop_p = scl_sync_reg & scl_last_reg & ~sda_last_reg & sda_sync_reg;
  end
endmodule : sspf_cond_det

`default_nettype wire

//--- sspf_i2c_peer.sv
`timescale 1ns/1ps
`default_nettype none
module sspf_i2c_peer
  import sspf_pkg::*;
#(
  parameter int QTR = 2
) (
  input wire logic sys_clk,
  input wire logic sda,
  output var logic scl_oe_n,
  output var logic sda_oe_n
);
  // A link period is four quarters of QTR cycles, 32 ns by default.
  // The slave answers three cycles after a clock fall, one before the rise.
  initial begin
    scl_oe_n = 1'b1;
    sda_oe_n = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n * QTR) @(posedge sys_clk);
  endtask : hold
  task automatic start_c();
    sda_oe_n <= 1'b0;
    hold(2);
    scl_oe_n <= 1'b0;
    hold(2);
  endtask : start_c
  task automatic stop_c();
    sda_oe_n <= 1'b0;
    hold(2);
    scl_oe_n <= 1'b1;
    hold(2);
    sda_oe_n <= 1'b1;
    hold(2);
  endtask : stop_c
  task automatic bit_c(input logic b, output logic s);
    sda_oe_n <= b;
    hold(1);
    scl_oe_n <= 1'b1;
    hold(2);
    s = sda;
    scl_oe_n <= 1'b0;
    hold(1);
  endtask : bit_c
  task automatic byte_c(input logic [8:0] d, output logic [8:0] s);
    for (int i = 8; i >= 0; i--) bit_c(d[i], s[i]);
  endtask : byte_c
endmodule : sspf_i2c_peer
`default_nettype wire

//--- sspf_status.sv
`timescale 1ns/1ps
`default_nettype none

module sspf_status
  import sspf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n
);
  logic scl_s, sda_s, scl_rise, scl_fall, start_p, stop_p;

  sspf_cond_det u_det (
    .sys_clk(sys_clk),
    .rst(rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_p(start_p),
    .stop_p(stop_p)
  );

  sspf_slv_e slv_reg, slv_next;
  sspf_mph_e mph_reg, mph_next;
  logic [3:0] bitcnt_reg, bitcnt_next, mcnt_reg, mcnt_next;
  logic [7:0] shreg_reg, shreg_next, mshreg_reg, mshreg_next;
  logic [7:0] rxbuf_reg, rxbuf_next, txbuf_reg, txbuf_next;
  logic [7:0] saddr_reg, saddr_next;
  logic [CTL_W-1:0] ctl_reg, ctl_next;
  logic [IRQ_W-1:0] istat_reg, istat_next, imask_reg, imask_next;
  logic [DIV_W-1:0] div_reg, div_next;
  logic stop_reg, stop_next, start_reg, start_next;
  logic rw_reg, rw_next, ua_reg, ua_next, bf_reg, bf_next;
  logic txdir_reg, txdir_next, mtx_reg, mtx_next;
  logic irq_reg, irq_next, wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic scl_oe_n_reg, scl_oe_n_next, sda_oe_n_reg, sda_oe_n_next;

  logic req, acc, en, master, tick, match, idle;
  logic [7:0] status;
  logic [IRQ_W-1:0] ev;

  always_comb begin
    req = avs_read | avs_write;
    acc = req & ~wait_reg;
    en = ctl_reg[CTL_ENABLE];
    master = ctl_reg[CTL_MASTER];
    tick = (div_reg == DIV_ZERO);
    // Idle needs every sequence enable and the transmit flag low.
    idle = ~(mtx_reg | ctl_reg[CTL_SEN] | ctl_reg[CTL_REPEAT_START_ENABLE] |
             ctl_reg[CTL_PEN] | ctl_reg[CTL_RECEIVE_ENABLE] | ctl_reg[CTL_ACK_SEQUENCE_ENABLE]);
    status = BYTE_ZERO;
    status[ST_STOP] = stop_reg;
    status[ST_START] = start_reg;
    // Master mode reports the transfer, slave mode the latched bit.
    status[ST_RW] = master ? mtx_reg : rw_reg;
    status[ST_UA] = ua_reg;
    status[ST_BF] = bf_reg;
    if (ctl_reg[CTL_TENBIT]) begin
      match = (shreg_reg[7:3] == TENBIT_HDR) &&
              (shreg_reg[2:1] == saddr_reg[2:1]);
    end else begin
      match = (shreg_reg[7:1] == saddr_reg[7:1]);
    end
  end

  always_comb begin
    slv_next = slv_reg;
    mph_next = mph_reg;
    bitcnt_next = bitcnt_reg;
    mcnt_next = mcnt_reg;
    shreg_next = shreg_reg;
    mshreg_next = mshreg_reg;
    rxbuf_next = rxbuf_reg;
    txbuf_next = txbuf_reg;
    saddr_next = saddr_reg;
    ctl_next = ctl_reg;
    istat_next = istat_reg;
    imask_next = imask_reg;
    stop_next = stop_reg;
    start_next = start_reg;
    rw_next = rw_reg;
    ua_next = ua_reg;
    bf_next = bf_reg;
    txdir_next = txdir_reg;
    mtx_next = mtx_reg;
    scl_oe_n_next = scl_oe_n_reg;
    sda_oe_n_next = sda_oe_n_reg;
    rdata_next = rdata_reg;
    ev = '0;
    div_next = tick ? DIV_RELOAD : div_reg - 1'b1;
    // A request is held one cycle so the read mux settles first.
    wait_next = ~(req & wait_reg);
    if (req && wait_reg) begin
      case (avs_address)
        ADDR_STATUS: rdata_next = {24'h000000, status};
        ADDR_CONTROL: rdata_next = {19'h00000, ctl_reg};
        ADDR_SLAVE: rdata_next = {24'h000000, saddr_reg};
        ADDR_BUFFER: rdata_next = {24'h000000, rxbuf_reg};
        ADDR_IRQ_STAT: rdata_next = {29'h00000000, istat_reg};
        ADDR_IRQ_MASK: rdata_next = {29'h00000000, imask_reg};
        ADDR_IDLE: rdata_next = {31'h00000000, idle};
        default: rdata_next = WORD_ZERO;
      endcase
    end

    if (acc && avs_write) begin
      case (avs_address)
        ADDR_CONTROL: ctl_next = avs_writedata[CTL_W-1:0];
        ADDR_SLAVE: begin
          saddr_next = avs_writedata[7:0];
          ua_next = 1'b0;
        end
        ADDR_BUFFER: begin
          txbuf_next = avs_writedata[7:0];
          bf_next = 1'b1;
          if (en && master && !mtx_reg) begin
            mtx_next = 1'b1;
            mshreg_next = avs_writedata[7:0];
            mcnt_next = BIT_ZERO;
            mph_next = MPH_DATA;
            div_next = DIV_RELOAD;
          end
        end
        ADDR_IRQ_STAT: istat_next = istat_reg & ~avs_writedata[IRQ_W-1:0];
        ADDR_IRQ_MASK: imask_next = avs_writedata[IRQ_W-1:0];
        default: ;
      endcase
    end
    if (acc && avs_read && avs_address == ADDR_BUFFER && !txdir_reg) begin
      bf_next = 1'b0;
    end

    if (en && start_p) begin
      start_next = 1'b1;
      stop_next = 1'b0;
      ev[IRQ_START] = 1'b1;
    end else if (en && stop_p) begin
      stop_next = 1'b1;
      start_next = 1'b0;
      ev[IRQ_STOP] = 1'b1;
    end

    if (en && !master) begin
      if (start_p || stop_p) begin
        // The latched direction stops being meaningful here.
        rw_next = 1'b0;
        txdir_next = 1'b0;
        sda_oe_n_next = 1'b1;
        bitcnt_next = BIT_ZERO;
        slv_next = start_p ? SLV_ADDR : SLV_IDLE;
      end else begin
        case (slv_reg)
          SLV_ADDR, SLV_RX: begin
            if (scl_rise && bitcnt_reg != BIT_DONE) begin
              shreg_next = {shreg_reg[6:0], sda_s};
              bitcnt_next = bitcnt_reg + 1'b1;
            end
            if (scl_fall && bitcnt_reg == BIT_DONE) begin
              if (slv_reg == SLV_RX) begin
                rxbuf_next = shreg_reg;
                bf_next = 1'b1;
                ev[IRQ_BYTE] = 1'b1;
                sda_oe_n_next = 1'b0;
                slv_next = SLV_ACK;
              end else if (match) begin
                rw_next = shreg_reg[0];
                txdir_next = shreg_reg[0];
                ua_next = ctl_reg[CTL_TENBIT];
                sda_oe_n_next = 1'b0;
                slv_next = SLV_ACK;
              end else begin
                slv_next = SLV_IDLE;
              end
            end
          end
          SLV_ACK: begin
            if (scl_fall) begin
              bitcnt_next = BIT_ZERO;
              if (txdir_reg) begin
                shreg_next = txbuf_reg;
                sda_oe_n_next = txbuf_reg[7];
                slv_next = SLV_TX;
              end else begin
                sda_oe_n_next = 1'b1;
                slv_next = SLV_RX;
              end
            end
          end
          SLV_TX: begin
            if (scl_rise) begin
              bitcnt_next = bitcnt_reg + 1'b1;
              if (bitcnt_reg == BIT_LAST) begin
                bf_next = 1'b0;
                ev[IRQ_BYTE] = 1'b1;
              end
            end
            if (scl_fall) begin
              if (bitcnt_reg == BIT_DONE) begin
                sda_oe_n_next = 1'b1;
                slv_next = SLV_TACK;
              end else begin
                sda_oe_n_next = shreg_reg[6];
                shreg_next = {shreg_reg[6:0], 1'b1};
              end
            end
          end
          SLV_TACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                rw_next = 1'b0;
                txdir_next = 1'b0;
                slv_next = SLV_IDLE;
              end else begin
                slv_next = SLV_ACK;
              end
            end
          end
          default: slv_next = SLV_IDLE;
        endcase
      end
    end

    // Master sends one byte at a fixed rate; the conditions stay software's.
    if (en && master && mtx_reg && tick) begin
      case (mph_reg)
        MPH_DATA: begin
          scl_oe_n_next = 1'b0;
          sda_oe_n_next = (mcnt_reg == BIT_DONE) ? 1'b1 : mshreg_reg[7];
          mph_next = MPH_HIGH;
        end
        MPH_HIGH: begin
          scl_oe_n_next = 1'b1;
          mph_next = MPH_LOW;
        end
        MPH_LOW: begin
          scl_oe_n_next = 1'b0;
          mshreg_next = {mshreg_reg[6:0], 1'b1};
          mcnt_next = mcnt_reg + 1'b1;
          mph_next = MPH_DATA;
          if (mcnt_reg == BIT_LAST) begin
            bf_next = 1'b0;
            ev[IRQ_BYTE] = 1'b1;
          end
          if (mcnt_reg == BIT_DONE) begin
            mtx_next = 1'b0;
            scl_oe_n_next = 1'b1;
            sda_oe_n_next = 1'b1;
          end
        end
        default: mph_next = MPH_DATA;
      endcase
    end

    if (!en) begin
      stop_next = 1'b0;
      start_next = 1'b0;
      rw_next = 1'b0;
      ua_next = 1'b0;
      bf_next = 1'b0;
      txdir_next = 1'b0;
      mtx_next = 1'b0;
      slv_next = SLV_IDLE;
      scl_oe_n_next = 1'b1;
      sda_oe_n_next = 1'b1;
    end

    // Events are merged after the software clear so a set is never lost.
    istat_next = istat_next | ev;
    irq_next = |(istat_next & imask_next);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      slv_reg <= SLV_IDLE;
      mph_reg <= MPH_DATA;
      bitcnt_reg <= BIT_ZERO;
      mcnt_reg <= BIT_ZERO;
      shreg_reg <= BYTE_ZERO;
      mshreg_reg <= BYTE_ZERO;
      rxbuf_reg <= BYTE_ZERO;
      txbuf_reg <= BYTE_ZERO;
      saddr_reg <= BYTE_ZERO;
      ctl_reg <= CTL_RESET;
      istat_reg <= '0;
      imask_reg <= '0;
      div_reg <= DIV_RELOAD;
      stop_reg <= 1'b0;
      start_reg <= 1'b0;
      rw_reg <= 1'b0;
      ua_reg <= 1'b0;
      bf_reg <= 1'b0;
      txdir_reg <= 1'b0;
      mtx_reg <= 1'b0;
      irq_reg <= 1'b0;
      wait_reg <= 1'b1;
      rdata_reg <= WORD_ZERO;
      scl_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
    end else begin
      slv_reg <= slv_next;
      mph_reg <= mph_next;
      bitcnt_reg <= bitcnt_next;
      mcnt_reg <= mcnt_next;
      shreg_reg <= shreg_next;
      mshreg_reg <= mshreg_next;
      rxbuf_reg <= rxbuf_next;
      txbuf_reg <= txbuf_next;
      saddr_reg <= saddr_next;
      ctl_reg <= ctl_next;
      istat_reg <= istat_next;
      imask_reg <= imask_next;
      div_reg <= div_next;
      stop_reg <= stop_next;
      start_reg <= start_next;
      rw_reg <= rw_next;
      ua_reg <= ua_next;
      bf_reg <= bf_next;
      txdir_reg <= txdir_next;
      mtx_reg <= mtx_next;
      irq_reg <= irq_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      scl_oe_n_reg <= scl_oe_n_next;
      sda_oe_n_reg <= sda_oe_n_next;
    end
  end

  // Both lines are open drain, so the driven level is always low.
  always_comb begin
    avs_readdata = rdata_reg;
    avs_waitrequest = wait_reg;
    irq = irq_reg;
    scl_o = 1'b0;
    sda_o = 1'b0;
    scl_oe_n = scl_oe_n_reg;
    sda_oe_n = sda_oe_n_reg;
  end
endmodule : sspf_status

`default_nettype wire

//--- sspf_status_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sspf_status_checker
  import sspf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic scl_oe_n,
  input wire logic sda_oe_n
);
  logic ctl_wr, st_rd, en_reg, en_next, mst_reg, mst_next;
  assign ctl_wr = avs_write && !avs_waitrequest && avs_address == ADDR_CONTROL;
  assign st_rd = avs_read && !avs_waitrequest && avs_address == ADDR_STATUS;
  always_comb begin
    en_next = ctl_wr ? avs_writedata[CTL_ENABLE] : en_reg;
    mst_next = ctl_wr ? avs_writedata[CTL_MASTER] : mst_reg;
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      en_reg <= 1'b0;
      mst_reg <= 1'b0;
    end else begin
      en_reg <= en_next;
      mst_reg <= mst_next;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_answer_next: assert property ((avs_read || avs_write) &&
    avs_waitrequest |=> !avs_waitrequest) else $error("answer late");
  chk_answer_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held too long");
  chk_no_spurious: assert property (!(avs_read || avs_write) |=>
    avs_waitrequest) else $error("answer without request");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest &&
    avs_address > ADDR_IDLE |-> avs_readdata == WORD_ZERO)
    else $error("unmapped read not zero");
  chk_status_upper: assert property (st_rd |-> avs_readdata[31:5] == 27'h0)
    else $error("status upper bits set");
  chk_flags_exclusive: assert property (
    st_rd |-> !(avs_readdata[ST_STOP] && avs_readdata[ST_START]))
    else $error("start and stop both set");
  chk_disabled_flags: assert property (
    st_rd && !en_reg && $past(en_reg, 3) == 1'b0 |->
    avs_readdata[ST_STOP:ST_START] == 2'h0) else $error("flag while off");
  chk_disabled_quiet: assert property (!en_reg && !$past(en_reg) |->
    sda_oe_n && scl_oe_n) else $error("pin driven while off");
  chk_slave_scl_free: assert property (!mst_reg && !$past(mst_reg) |->
    scl_oe_n) else $error("slave pulled clock");
  chk_mask_gates_irq: assert property (avs_write && !avs_waitrequest &&
    avs_address == ADDR_IRQ_MASK && avs_writedata[IRQ_W-1:0] == 3'h0
    |-> ##2 !irq) else $error("masked interrupt");
  cover property ($rose(irq));
  cover property ($fell(sda_oe_n));
  cover property ($fell(scl_oe_n));
endmodule : sspf_status_checker
bind sspf_status sspf_status_checker i_sspf_status_checker (.sys_clk,
  .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_readdata, .avs_waitrequest, .irq, .scl_oe_n, .sda_oe_n);
`default_nettype wire

//--- tb_sspf_status.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin miscompares++; \
  $display("Error %0t: got %0h want %0h", $time, a, e); end end
module tb_sspf_status;
  import sspf_pkg::*;
  typedef struct {logic [7:0] wa; logic [31:0] wd; logic [7:0] ra;
    logic [31:0] e;} sspf_row_s;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, irq, scl_oe_n, sda_oe_n, p_scl_oe_n, p_sda_oe_n;
  logic [8:0] r;
  logic [7:0] rb;
  int miscompares = 0;
  int checks = 0;
  // Open-drain lines with pull-ups: low when any party enables its driver.
  wire scl = scl_oe_n & p_scl_oe_n;
  wire sda = sda_oe_n & p_sda_oe_n;
  sspf_row_s rows [9] = '{
    '{ADDR_CONTROL, 32'h100, ADDR_IDLE, 32'h0},
    '{ADDR_CONTROL, 32'h200, ADDR_IDLE, 32'h0},
    '{ADDR_CONTROL, 32'h400, ADDR_IDLE, 32'h0},
    '{ADDR_CONTROL, 32'h800, ADDR_IDLE, 32'h0},
    '{ADDR_CONTROL, 32'h1000, ADDR_IDLE, 32'h0},
    '{ADDR_CONTROL, 32'h0, ADDR_IDLE, 32'h1},
    '{ADDR_SLAVE, 32'hA4, ADDR_SLAVE, 32'hA4},
    '{ADDR_IRQ_MASK, 32'h7, ADDR_IRQ_MASK, 32'h7},
    '{8'h1C, 32'hFF, 8'h1C, 32'h0}};
  sspf_status i_sspf_status (.sys_clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq,
    .scl_i(scl), .scl_o(), .scl_oe_n, .sda_i(sda), .sda_o(), .sda_oe_n);
  sspf_i2c_peer i_sspf_i2c_peer (.sys_clk, .sda, .scl_oe_n(p_scl_oe_n),
    .sda_oe_n(p_sda_oe_n));
  always #2 sys_clk = ~sys_clk;
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask : rc
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  initial begin
    repeat (90000) @(posedge sys_clk);
    miscompares++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rc(ADDR_STATUS, 32'h0);
    `CHK(irq, 1'b0)
    foreach (rows[i]) begin
      bus(1'b1, rows[i].wa, rows[i].wd);
      rc(rows[i].ra, rows[i].e);
    end
    bus(1'b1, ADDR_CONTROL, 32'h20);
    i_sspf_i2c_peer.start_c();
    rc(ADDR_STATUS, 32'h08);
    i_sspf_i2c_peer.byte_c(9'h149, r);
    `CHK(r[0], 1'b0)
    rc(ADDR_STATUS, 32'h08);
    bus(1'b1, ADDR_IRQ_STAT, 32'h7);
    i_sspf_i2c_peer.byte_c(9'h0B5, r);
    rc(ADDR_STATUS, 32'h09);
    `CHK(irq, 1'b1)
    rc(ADDR_BUFFER, 32'h5A);
    rc(ADDR_STATUS, 32'h08);
    bus(1'b1, ADDR_IRQ_STAT, 32'h7);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    i_sspf_i2c_peer.stop_c();
    rc(ADDR_STATUS, 32'h10);
    bus(1'b1, ADDR_BUFFER, 32'h3C);
    i_sspf_i2c_peer.start_c();
    rc(ADDR_STATUS, 32'h09);
    i_sspf_i2c_peer.byte_c(9'h14B, r);
    rc(ADDR_STATUS, 32'h0D);
    for (int i = 7; i >= 0; i--) begin
      if (i == 0) rc(ADDR_STATUS, 32'h0D);
      i_sspf_i2c_peer.bit_c(1'b1, rb[i]);
    end
    rc(ADDR_STATUS, 32'h0C);
    `CHK(rb, 8'h3C)
    i_sspf_i2c_peer.bit_c(1'b1, r[0]);
    rc(ADDR_STATUS, 32'h08);
    i_sspf_i2c_peer.stop_c();
    bus(1'b1, ADDR_CONTROL, 32'h0);
    rc(ADDR_STATUS, 32'h0);
    bus(1'b1, ADDR_CONTROL, 32'h22);
    i_sspf_i2c_peer.start_c();
    i_sspf_i2c_peer.byte_c(9'h1E9, r);
    rc(ADDR_STATUS, 32'h0A);
    bus(1'b1, ADDR_SLAVE, 32'hA4);
    rc(ADDR_STATUS, 32'h08);
    i_sspf_i2c_peer.stop_c();
    bus(1'b1, ADDR_IRQ_STAT, 32'h7);
    bus(1'b1, ADDR_CONTROL, 32'h21);
    bus(1'b1, ADDR_BUFFER, 32'h96);
    rc(ADDR_STATUS, 32'h15);
    rc(ADDR_IDLE, 32'h0);
    for (int i = 7; i >= 0; i--) begin
      @(posedge scl);
      rb[i] = sda;
    end
    `CHK(rb, 8'h96)
    @(posedge scl);
    rc(ADDR_STATUS, 32'h14);
    // The ack clock runs on for a fixed span, so poll rather than count.
    while (q[ST_RW] !== 1'b0) bus(1'b0, ADDR_STATUS, 32'h0);
    rc(ADDR_STATUS, 32'h10);
    rc(ADDR_IDLE, 32'h1);
    `CHK(irq, 1'b1)
    bus(1'b1, ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    // A reset in mid-run must drop the stop flag left by the last frame.
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rc(ADDR_STATUS, 32'h0);
    summarize();
  end
endmodule : tb_sspf_status
`default_nettype wire
